// [common/ncs_params.svh]
`ifndef NCS_PARAMS_SVH
`define NCS_PARAMS_SVH
// core clock rate and pin timing, least times
`define NCS_CLK_MHZ 200
`define NCS_T_STROBE_LOW_NS 25
`define NCS_T_STROBE_HIGH_NS 25
`define NCS_T_BUSY_ONSET_NS 100
`define NCS_NS_TO_CYC(ns) ((((ns) * `NCS_CLK_MHZ) + 999) / 1000)
`define NCS_SYNC_CYC 2
// command bytes
`define NCS_CMD_READ 8'h00
`define NCS_CMD_CB_READ 8'h35
`define NCS_CMD_CB_PROG 8'h85
`define NCS_CMD_PROG 8'h10
`define NCS_CMD_DUMMY 8'h11
`define NCS_CMD_SER_IN 8'h80
`define NCS_CMD_PLANE2 8'h81
`define NCS_CMD_ERASE 8'h60
`define NCS_CMD_CONFIRM 8'hd0
`define NCS_CMD_STAT 8'h70
`define NCS_CMD_EDC_STAT 8'h7b
// array geometry
`define NCS_PAGE_BYTES 2112
`define NCS_ROW_W 18
`define NCS_COL_W 12
`define NCS_CNT_W 12
`define NCS_PLANE_BIT 6
`define NCS_ERASE_IGN_W 6
// address selectors carried in a step argument
`define NCS_SEL_DST 0
`define NCS_SEL_FLIP 1
// register byte offsets
`define NCS_AXI_AW 5
`define NCS_OFF_CTRL 5'h00
`define NCS_OFF_STATUS 5'h04
`define NCS_OFF_SRC 5'h08
`define NCS_OFF_DST 5'h0c
`define NCS_OFF_COL 5'h10
`define NCS_OFF_COUNT 5'h14
`define NCS_OFF_WDATA 5'h18
// field positions
`define NCS_CTRL_GO 0
`define NCS_CTRL_OP_LO 1
`define NCS_CTRL_OP_HI 3
`define NCS_ST_BUSY 8
`define NCS_ST_DONE 9
`define NCS_ST_REFUSED 10
`define NCS_ST_WFULL 11
`define NCS_RESP_OKAY 2'h0
`define NCS_RESP_SLVERR 2'h2
`endif

// [common/ncs_pkg.sv]
package ncs_pkg;
	typedef enum logic [2:0] {
		NCS_OP_COPYBACK = 3'h0,
		NCS_OP_ERASE = 3'h1,
		NCS_OP_ERASE2 = 3'h2,
		NCS_OP_PROG2 = 3'h3,
		NCS_OP_COPYBACK2 = 3'h4,
		NCS_OP_STATUS = 3'h5,
		NCS_OP_EDC_STATUS = 3'h6
	} ncs_op_type;
	typedef enum logic [2:0] {
		UC_CMD = 3'h0, UC_ADR5 = 3'h1, UC_ADR3 = 3'h2, UC_DATA = 3'h3,
		UC_WAIT = 3'h4, UC_STAT = 3'h5, UC_END = 3'h6
	} ncs_uc_type;
	typedef struct packed {
		ncs_uc_type code;
		logic [7:0] arg;
	} ncs_step_type;
	typedef enum logic [1:0] {
		KIND_CMD = 2'h0, KIND_ADDR = 2'h1, KIND_WDAT = 2'h2, KIND_RDAT = 2'h3
	} ncs_kind_type;
	typedef enum logic [3:0] {
		SEQ_IDLE = 4'h1, SEQ_FETCH = 4'h2, SEQ_CYC = 4'h4, SEQ_RB = 4'h8
	} ncs_seq_type;
	typedef enum logic [3:0] {
		PH_IDLE = 4'h1, PH_SETUP = 4'h2, PH_LOW = 4'h4, PH_HIGH = 4'h8
	} ncs_phase_type;
endpackage

// [src/ncs_cycle.sv]
`timescale 1ns/10ps
`default_nettype none
`include "ncs_params.svh"
module ncs_cycle
	import ncs_pkg::*;
#(
	parameter int LOW_CYC = `NCS_NS_TO_CYC(`NCS_T_STROBE_LOW_NS),
	parameter int HIGH_CYC = `NCS_NS_TO_CYC(`NCS_T_STROBE_HIGH_NS)
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic start,
	input wire ncs_kind_type kind,
	input wire logic [7:0] wbyte,
	input wire logic [7:0] io_sync,
	output logic done,
	output logic [7:0] rbyte,
	output logic cmd_latch,
	output logic addr_latch,
	output logic write_strobe_n,
	output logic read_strobe_n,
	output logic [7:0] io_out,
	output logic [7:0] io_oe
);
	// read low phase also spans the pin synchroniser
	localparam int RD_LOW = LOW_CYC + `NCS_SYNC_CYC;
	if (LOW_CYC < 1 || HIGH_CYC < 1 || RD_LOW > 255) begin : g_chk
		$error("ncs_cycle: strobe counts out of range");
	end
	ncs_phase_type phase;
	ncs_kind_type kind_q;
	logic [7:0] cnt;
	logic is_rd;
	assign is_rd = (kind_q == KIND_RDAT);

	// phase sequencer: setup, strobe low, strobe high
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			phase <= PH_IDLE;
			cnt <= 8'h00;
			kind_q <= KIND_CMD;
			done <= 1'b0;
		end else begin
			done <= 1'b0;
			case (phase)
			PH_IDLE: if (start) begin
				phase <= PH_SETUP;
				kind_q <= kind;
			end
			PH_SETUP: begin
				phase <= PH_LOW;
				cnt <= is_rd ? 8'(RD_LOW - 1) : 8'(LOW_CYC - 1);
			end
			PH_LOW: if (cnt == 8'h00) begin
				phase <= PH_HIGH;
				cnt <= 8'(HIGH_CYC - 1);
			end else begin
				cnt <= cnt - 8'h01;
			end
			PH_HIGH: if (cnt == 8'h00) begin
				phase <= PH_IDLE;
				done <= 1'b1;
			end else begin
				cnt <= cnt - 8'h01;
			end
			default: phase <= PH_IDLE;
			endcase
		end
	end

	// pins; latches and bus stay through the high phase for hold time
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cmd_latch <= 1'b0;
			addr_latch <= 1'b0;
			write_strobe_n <= 1'b1;
			read_strobe_n <= 1'b1;
			io_out <= 8'h00;
			io_oe <= 8'h00;
			rbyte <= 8'h00;
		end else begin
			if (phase == PH_IDLE && start) begin
				cmd_latch <= (kind == KIND_CMD);
				addr_latch <= (kind == KIND_ADDR);
				io_out <= wbyte;
				io_oe <= {8{kind != KIND_RDAT}};
			end
			if (phase == PH_SETUP) begin
				write_strobe_n <= is_rd;
				read_strobe_n <= !is_rd;
			end
			if (phase == PH_LOW && cnt == 8'h00) begin
				write_strobe_n <= 1'b1;
				read_strobe_n <= 1'b1;
				if (is_rd) begin
					rbyte <= io_sync;
				end
			end
			if (phase == PH_HIGH && cnt == 8'h00) begin
				cmd_latch <= 1'b0;
				addr_latch <= 1'b0;
				io_oe <= 8'h00;
			end
		end
	end

	default clocking cb_cyc @(posedge clk); endclocking
	default disable iff (!rst_n);
	rd_low_len_a: assert property ($fell(read_strobe_n) |-> !read_strobe_n [*7] ##1 read_strobe_n)
		else $error("read strobe low time wrong");
	wr_low_len_a: assert property ($fell(write_strobe_n) |-> !write_strobe_n [*5] ##1 write_strobe_n)
		else $error("write strobe low time wrong");
	no_drive_rd_a: assert property (!read_strobe_n |-> io_oe == 8'h00)
		else $error("bus driven during read");
endmodule // ncs_cycle
`default_nettype wire

// [src/ncs_seq.sv]
// Function
// - after ready, controller writes 85h, destination address, then 10h.
// - completion shows on ready/busy pin and status bit 6; either may be used.
// - copy-back only within one plane and between pages of equal parity.
// - with error detection, random data input at most once per address.
// - erase starts with 60h and three row cycles; A12-A17 are ignored.
// - two-plane program loads up to 2112 bytes, then 11h gives short busy.
// - after dummy busy, 81h with address and data, then 10h programs both.
// - both planes share the row address except A18, the plane select.
// - between 11h and 81h only 70h or FFh may be issued.
// - two-plane erase repeats 60h and three address cycles, then D0h.
// - after status reads, 00h must precede further data read cycles.
// - a page program, first plane included, starts with 80h and five addresses.
//
// Register access over AXI4-Lite and the placing of the registers were decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "ncs_params.svh"
module ncs_seq
	import ncs_pkg::*;
#(
	parameter int PAGE_BYTES = `NCS_PAGE_BYTES
) (
	input wire logic CORE_CLK,
	input wire logic NRST,
	input wire logic [`NCS_AXI_AW-1:0] S_AXI_AWADDR,
	input wire logic S_AXI_AWVALID,
	output logic S_AXI_AWREADY,
	input wire logic [31:0] S_AXI_WDATA,
	input wire logic [3:0] S_AXI_WSTRB,
	input wire logic S_AXI_WVALID,
	output logic S_AXI_WREADY,
	output logic [1:0] S_AXI_BRESP,
	output logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic [`NCS_AXI_AW-1:0] S_AXI_ARADDR,
	input wire logic S_AXI_ARVALID,
	output logic S_AXI_ARREADY,
	output logic [31:0] S_AXI_RDATA,
	output logic [1:0] S_AXI_RRESP,
	output logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	output logic NAND_CLE,
	output logic NAND_ALE,
	output logic NAND_CHIP_EN_N,
	output logic NAND_WRITE_STROBE_N,
	output logic NAND_READ_STROBE_N,
	output logic NAND_WRITE_PROT_N,
	input wire logic [7:0] NAND_IO_I,
	output logic [7:0] NAND_IO_O,
	output logic [7:0] NAND_IO_OE,
	input wire logic NAND_READY
);
	localparam logic [7:0] WB_CYC = 8'(`NCS_NS_TO_CYC(`NCS_T_BUSY_ONSET_NS));
	localparam ncs_step_type S_END = '{UC_END, 8'h00};
	localparam ncs_step_type S_WAIT = '{UC_WAIT, 8'h00};
	localparam ncs_step_type S_DATA = '{UC_DATA, 8'h00};
	localparam ncs_step_type S_STAT = '{UC_STAT, 8'h00};
	if (PAGE_BYTES < 1 || PAGE_BYTES >= (1 << `NCS_CNT_W)) begin : g_chk
		$error("ncs_seq: PAGE_BYTES out of range");
	end

	logic [`NCS_ROW_W-1:0] src_row, dst_row, row_sel;
	logic [`NCS_COL_W-1:0] col;
	logic [`NCS_CNT_W-1:0] count, bcnt;
	logic [7:0] wbyte, stat_byte, wb_cnt, last_cmd, addr_byte, cyc_byte, cyc_rbyte;
	logic [7:0] io_m, io_s;
	logic rdy_m, rdy_s, wfull, done, refused, cap, cyc_start, cyc_done;
	logic wr_go, rd_go, go, bad, accept, take, end_pulse, wfull_set, chip_en_n;
	logic [2:0] sub, last_sub, ai;
	logic [4:0] idx;
	logic [31:0] rd_mux;
	ncs_op_type op, op_new;
	ncs_seq_type st;
	ncs_step_type step;
	ncs_kind_type cyc_kind, last_kind;

	function automatic ncs_step_type cm(input logic [7:0] b);
		return '{UC_CMD, b};
	endfunction
	function automatic ncs_step_type a5(input logic [7:0] s);
		return '{UC_ADR5, s};
	endfunction
	function automatic ncs_step_type a3(input logic [7:0] s);
		return '{UC_ADR3, s};
	endfunction
	// byte-lane merge of a register write
	function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
		input logic [3:0] s);
		for (int k = 0; k < 4; k++) begin
			if (s[k]) begin
				o[8*k +: 8] = n[8*k +: 8];
			end
		end
		return o;
	endfunction

	// step tables; address arg bit0 picks destination, bit1 flips the plane
	function automatic ncs_step_type step_of(input ncs_op_type o, input logic [4:0] i);
		ncs_step_type t [0:18];
		t = '{default: S_END};
		case (o)
		NCS_OP_COPYBACK: t = '{0: cm(`NCS_CMD_READ), 1: a5(8'h00),
			2: cm(`NCS_CMD_CB_READ), 3: S_WAIT, 4: cm(`NCS_CMD_CB_PROG),
			5: a5(8'h01), 6: cm(`NCS_CMD_PROG), 7: S_WAIT,
			8: cm(`NCS_CMD_EDC_STAT), 9: S_STAT, default: S_END};
		NCS_OP_ERASE: t = '{0: cm(`NCS_CMD_ERASE), 1: a3(8'h00),
			2: cm(`NCS_CMD_CONFIRM), 3: S_WAIT, 4: cm(`NCS_CMD_STAT),
			5: S_STAT, default: S_END};
		NCS_OP_ERASE2: t = '{0: cm(`NCS_CMD_ERASE), 1: a3(8'h00),
			2: cm(`NCS_CMD_ERASE), 3: a3(8'h02), 4: cm(`NCS_CMD_CONFIRM),
			5: S_WAIT, 6: cm(`NCS_CMD_STAT), 7: S_STAT, default: S_END};
		NCS_OP_PROG2: t = '{0: cm(`NCS_CMD_SER_IN), 1: a5(8'h01), 2: S_DATA,
			3: cm(`NCS_CMD_DUMMY), 4: S_WAIT, 5: cm(`NCS_CMD_PLANE2),
			6: a5(8'h03), 7: S_DATA, 8: cm(`NCS_CMD_PROG), 9: S_WAIT,
			10: cm(`NCS_CMD_STAT), 11: S_STAT, default: S_END};
		NCS_OP_COPYBACK2: t = '{0: cm(`NCS_CMD_READ), 1: a5(8'h00),
			2: cm(`NCS_CMD_CB_READ), 3: S_WAIT, 4: cm(`NCS_CMD_READ),
			5: a5(8'h02), 6: cm(`NCS_CMD_CB_READ), 7: S_WAIT,
			8: cm(`NCS_CMD_CB_PROG), 9: a5(8'h01), 10: cm(`NCS_CMD_DUMMY),
			11: S_WAIT, 12: cm(`NCS_CMD_PLANE2), 13: a5(8'h03),
			14: cm(`NCS_CMD_PROG), 15: S_WAIT, 16: cm(`NCS_CMD_EDC_STAT),
			17: S_STAT, default: S_END};
		NCS_OP_STATUS: t = '{0: cm(`NCS_CMD_STAT), 1: S_STAT, default: S_END};
		NCS_OP_EDC_STATUS: t = '{0: cm(`NCS_CMD_EDC_STAT), 1: S_STAT, default: S_END};
		default: t = '{default: S_END};
		endcase
		return (i > 5'd18) ? S_END : t[i];
	endfunction

	// two-flop synchronisers for the pins
	always_ff @(posedge CORE_CLK or negedge NRST) begin
		if (!NRST) begin
			io_m <= 8'h00;
			io_s <= 8'h00;
			rdy_m <= 1'b0;
			rdy_s <= 1'b0;
		end else begin
			io_m <= NAND_IO_I;
			io_s <= io_m;
			rdy_m <= NAND_READY;
			rdy_s <= rdy_m;
		end
	end

	// bus handshakes; one write and one read in flight at most
	assign wr_go = S_AXI_AWVALID && S_AXI_WVALID && !S_AXI_BVALID;
	assign S_AXI_AWREADY = wr_go;
	assign S_AXI_WREADY = wr_go;
	assign rd_go = S_AXI_ARVALID && !S_AXI_RVALID;
	assign S_AXI_ARREADY = !S_AXI_RVALID;

	// start request and its admission checks
	assign go = wr_go && S_AXI_AWADDR == `NCS_OFF_CTRL && S_AXI_WSTRB[0]
		&& S_AXI_WDATA[`NCS_CTRL_GO];
	assign op_new = ncs_op_type'(S_AXI_WDATA[`NCS_CTRL_OP_HI:`NCS_CTRL_OP_LO]);
	always_comb begin
		bad = (op_new > NCS_OP_EDC_STATUS);
		if (op_new == NCS_OP_COPYBACK || op_new == NCS_OP_COPYBACK2) begin
			// same plane and same page parity only
			bad = bad || (src_row[`NCS_PLANE_BIT] != dst_row[`NCS_PLANE_BIT])
				|| (src_row[0] != dst_row[0]);
		end
		if (op_new == NCS_OP_PROG2) begin
			bad = bad || count == '0 || count > `NCS_CNT_W'(PAGE_BYTES);
		end
	end
	assign accept = go && st == SEQ_IDLE && !bad;
	assign step = step_of(op, idx);
	assign end_pulse = (st == SEQ_FETCH) && (step.code == UC_END);

	// write response
	always_ff @(posedge CORE_CLK or negedge NRST) begin
		if (!NRST) begin
			S_AXI_BVALID <= 1'b0;
			S_AXI_BRESP <= `NCS_RESP_OKAY;
		end else if (wr_go) begin
			S_AXI_BVALID <= 1'b1;
			S_AXI_BRESP <= (S_AXI_AWADDR == `NCS_OFF_STATUS || S_AXI_AWADDR > `NCS_OFF_WDATA
				|| S_AXI_AWADDR[1:0] != 2'h0) ? `NCS_RESP_SLVERR : `NCS_RESP_OKAY;
		end else if (S_AXI_BREADY) begin
			S_AXI_BVALID <= 1'b0;
		end
	end

	// address and count registers; held stable while an operation runs
	always_ff @(posedge CORE_CLK or negedge NRST) begin
		if (!NRST) begin
			src_row <= '0;
			dst_row <= '0;
			col <= '0;
			count <= '0;
		end else if (wr_go && st == SEQ_IDLE) begin
			case (S_AXI_AWADDR)
			`NCS_OFF_SRC: src_row <= `NCS_ROW_W'(merge(32'(src_row), S_AXI_WDATA, S_AXI_WSTRB));
			`NCS_OFF_DST: dst_row <= `NCS_ROW_W'(merge(32'(dst_row), S_AXI_WDATA, S_AXI_WSTRB));
			`NCS_OFF_COL: col <= `NCS_COL_W'(merge(32'(col), S_AXI_WDATA, S_AXI_WSTRB));
			`NCS_OFF_COUNT: count <= `NCS_CNT_W'(merge(32'(count), S_AXI_WDATA, S_AXI_WSTRB));
			default: ;
			endcase
		end
	end

	// sticky flags; a hardware set wins over a same-cycle clear
	assign wfull_set = wr_go && S_AXI_AWADDR == `NCS_OFF_WDATA && S_AXI_WSTRB[0] && !wfull;
	always_ff @(posedge CORE_CLK or negedge NRST) begin
		if (!NRST) begin
			done <= 1'b0;
			refused <= 1'b0;
			wfull <= 1'b0;
			wbyte <= 8'h00;
		end else begin
			done <= end_pulse || (done && !accept);
			refused <= (go && st == SEQ_IDLE && bad) || (refused && !accept);
			wfull <= wfull_set || (wfull && !take);
			if (wfull_set) begin
				wbyte <= S_AXI_WDATA[7:0];
			end
		end
	end

	// read data mux, registered on the accepting edge
	always_comb begin
		case (S_AXI_ARADDR)
		`NCS_OFF_CTRL: rd_mux = {28'h0, op, 1'b0};
		`NCS_OFF_STATUS: rd_mux = {20'h0, wfull, refused, done, st != SEQ_IDLE, stat_byte};
		`NCS_OFF_SRC: rd_mux = 32'(src_row);
		`NCS_OFF_DST: rd_mux = 32'(dst_row);
		`NCS_OFF_COL: rd_mux = 32'(col);
		`NCS_OFF_COUNT: rd_mux = 32'(count);
		`NCS_OFF_WDATA: rd_mux = {24'h0, wbyte};
		default: rd_mux = 32'h0;
		endcase
	end
	always_ff @(posedge CORE_CLK or negedge NRST) begin
		if (!NRST) begin
			S_AXI_RVALID <= 1'b0;
			S_AXI_RDATA <= 32'h0;
			S_AXI_RRESP <= `NCS_RESP_OKAY;
		end else if (rd_go) begin
			S_AXI_RVALID <= 1'b1;
			S_AXI_RDATA <= rd_mux;
			S_AXI_RRESP <= (S_AXI_ARADDR > `NCS_OFF_WDATA || S_AXI_ARADDR[1:0] != 2'h0)
				? `NCS_RESP_SLVERR : `NCS_RESP_OKAY;
		end else if (S_AXI_RREADY) begin
			S_AXI_RVALID <= 1'b0;
		end
	end

	// address byte: second plane differs only in the plane bit
	always_comb begin
		row_sel = step.arg[`NCS_SEL_DST] ? dst_row : src_row;
		if (step.arg[`NCS_SEL_FLIP]) begin
			row_sel[`NCS_PLANE_BIT] = !row_sel[`NCS_PLANE_BIT];
		end
		if (step.code == UC_ADR3) begin
			row_sel[`NCS_ERASE_IGN_W-1:0] = '0;
		end
		last_sub = (step.code == UC_ADR3) ? 3'h2 : 3'h4;
		ai = (step.code == UC_ADR3) ? sub + 3'h2 : sub;
		case (ai)
		3'h0: addr_byte = col[7:0];
		3'h1: addr_byte = 8'(col[`NCS_COL_W-1:8]);
		3'h2: addr_byte = row_sel[7:0];
		3'h3: addr_byte = row_sel[15:8];
		default: addr_byte = 8'(row_sel[`NCS_ROW_W-1:16]);
		endcase
	end

	// cycle issue from the fetched step; data steps stall on an empty byte
	always_comb begin
		cyc_start = 1'b0;
		cyc_kind = KIND_CMD;
		cyc_byte = 8'h00;
		if (st == SEQ_FETCH) begin
			case (step.code)
			UC_CMD: begin
				cyc_start = 1'b1;
				cyc_byte = step.arg;
			end
			UC_ADR5, UC_ADR3: begin
				cyc_start = 1'b1;
				cyc_kind = KIND_ADDR;
				cyc_byte = addr_byte;
			end
			UC_DATA: begin
				cyc_start = (bcnt != count) && wfull;
				cyc_kind = KIND_WDAT;
				cyc_byte = wbyte;
			end
			UC_STAT: begin
				cyc_start = 1'b1;
				cyc_kind = KIND_RDAT;
			end
			default: ;
			endcase
		end
	end
	assign take = cyc_start && cyc_kind == KIND_WDAT;

	// sequencer
	always_ff @(posedge CORE_CLK or negedge NRST) begin
		if (!NRST) begin
			st <= SEQ_IDLE;
			op <= NCS_OP_COPYBACK;
			idx <= 5'h00;
			sub <= 3'h0;
			bcnt <= '0;
			wb_cnt <= 8'h00;
			cap <= 1'b0;
		end else begin
			case (st)
			SEQ_IDLE: if (accept) begin
				op <= op_new;
				idx <= 5'h00;
				sub <= 3'h0;
				bcnt <= '0;
				st <= SEQ_FETCH;
			end
			SEQ_FETCH: begin
				cap <= (step.code == UC_STAT);
				case (step.code)
				UC_CMD, UC_STAT: begin
					idx <= idx + 5'h01;
					st <= SEQ_CYC;
				end
				UC_ADR5, UC_ADR3: begin
					sub <= (sub == last_sub) ? 3'h0 : sub + 3'h1;
					idx <= (sub == last_sub) ? idx + 5'h01 : idx;
					st <= SEQ_CYC;
				end
				UC_DATA: if (bcnt == count) begin
					bcnt <= '0;
					idx <= idx + 5'h01;
				end else if (wfull) begin
					bcnt <= bcnt + 1'b1;
					st <= SEQ_CYC;
				end
				UC_WAIT: begin
					wb_cnt <= WB_CYC - 8'h01;
					st <= SEQ_RB;
				end
				default: st <= SEQ_IDLE;
				endcase
			end
			SEQ_CYC: if (cyc_done) begin
				st <= SEQ_FETCH;
			end
			// give the device time to pull busy low before trusting ready
			SEQ_RB: if (wb_cnt != 8'h00) begin
				wb_cnt <= wb_cnt - 8'h01;
			end else if (rdy_s) begin
				idx <= idx + 5'h01;
				st <= SEQ_FETCH;
			end
			default: st <= SEQ_IDLE;
			endcase
		end
	end

	// status capture, chip select, command history
	always_ff @(posedge CORE_CLK or negedge NRST) begin
		if (!NRST) begin
			stat_byte <= 8'h00;
			chip_en_n <= 1'b1;
			last_cmd <= 8'h00;
			last_kind <= KIND_CMD;
		end else begin
			if (cyc_done && cap) begin
				stat_byte <= cyc_rbyte;
			end
			chip_en_n <= !(accept || (st != SEQ_IDLE && !end_pulse));
			if (cyc_start) begin
				last_kind <= cyc_kind;
				if (cyc_kind == KIND_CMD) begin
					last_cmd <= cyc_byte;
				end
			end
		end
	end
	assign NAND_CHIP_EN_N = chip_en_n;
	assign NAND_WRITE_PROT_N = 1'b1; // erase and program are never fenced here

	ncs_cycle u_cyc (
		.clk(CORE_CLK),
		.rst_n(NRST),
		.start(cyc_start),
		.kind(cyc_kind),
		.wbyte(cyc_byte),
		.io_sync(io_s),
		.done(cyc_done),
		.rbyte(cyc_rbyte),
		.cmd_latch(NAND_CLE),
		.addr_latch(NAND_ALE),
		.write_strobe_n(NAND_WRITE_STROBE_N),
		.read_strobe_n(NAND_READ_STROBE_N),
		.io_out(NAND_IO_O),
		.io_oe(NAND_IO_OE)
	);

	default clocking cb_seq @(posedge CORE_CLK); endclocking
	default disable iff (!NRST);
	cb_refuse_a: assert property (go && st == SEQ_IDLE && op_new == NCS_OP_COPYBACK
		&& src_row[0] != dst_row[0] |=> refused && st == SEQ_IDLE)
		else $error("bad copy-back pair not refused");
	rb_hold_a: assert property (st == SEQ_RB && wb_cnt == 8'h00 && !rdy_s |=> st == SEQ_RB)
		else $error("left busy wait while busy");
	dummy_next_a: assert property (cyc_start && cyc_kind == KIND_CMD
		&& last_cmd == `NCS_CMD_DUMMY |-> cyc_byte == `NCS_CMD_PLANE2)
		else $error("command other than 81h after 11h");
	dummy_wait_a: assert property (cyc_start && cyc_byte == `NCS_CMD_DUMMY
		&& cyc_kind == KIND_CMD |-> ##[1:30] st == SEQ_RB)
		else $error("no busy wait after 11h");
	cb_dest_a: assert property (cyc_start && cyc_kind == KIND_CMD
		&& cyc_byte == `NCS_CMD_CB_PROG |-> last_cmd == `NCS_CMD_CB_READ)
		else $error("85h not after copy-back read");
	erase_row_a: assert property (cyc_start && step.code == UC_ADR3 && sub == 3'h0
		|-> cyc_byte[`NCS_ERASE_IGN_W-1:0] == '0)
		else $error("ignored erase bits not cleared");
	confirm_addr_a: assert property (cyc_start && cyc_kind == KIND_CMD
		&& cyc_byte == `NCS_CMD_CONFIRM |-> last_kind == KIND_ADDR)
		else $error("D0h not after block address");
	plane_flip_a: assert property (cyc_start && step.code == UC_ADR5 && sub == 3'h2
		&& step.arg[`NCS_SEL_FLIP] |-> cyc_byte[`NCS_PLANE_BIT] != (step.arg[0]
		? dst_row[`NCS_PLANE_BIT] : src_row[`NCS_PLANE_BIT]))
		else $error("second plane address not flipped");
	prog_start_a: assert property (accept && op_new == NCS_OP_PROG2
		|=> cyc_start && cyc_byte == `NCS_CMD_SER_IN)
		else $error("program not opened with 80h");
	data_count_a: assert property (st == SEQ_FETCH && step.code == UC_DATA |-> bcnt <= count)
		else $error("more bytes than counted");
	cb_done_c: cover property (end_pulse && op == NCS_OP_COPYBACK);
	prog2_done_c: cover property (end_pulse && op == NCS_OP_PROG2);
	erase2_done_c: cover property (end_pulse && op == NCS_OP_ERASE2);
	refuse_c: cover property (go && st == SEQ_IDLE && bad);
endmodule // ncs_seq
`default_nettype wire

// [tb/ncs_flash_model.sv]
`timescale 1ns/10ps
`default_nettype none
module ncs_flash_model (
	input wire logic chip_en_n,
	input wire logic cle,
	input wire logic ale,
	input wire logic write_strobe_n,
	input wire logic read_strobe_n,
	input wire logic write_prot_n,
	input wire logic [7:0] io_host,
	input wire logic [7:0] host_oe,
	input wire logic fail,
	output logic [7:0] io_dev,
	output logic ready,
	output logic seq_err
);
	logic [7:0] mode = 8'h00;
	logic [7:0] acnt = 8'h00;
	logic err = 1'b0;
	logic [7:0] stat;
	initial ready = 1'b1;
	initial seq_err = 1'b0;
	// commands latch at the strobe rise; busy ones hold the pin low
	always @(posedge write_strobe_n) begin
		if (!chip_en_n && ale) begin
			acnt = acnt + 8'h01;
		end
		if (!chip_en_n && cle) begin
			mode = io_host;
			// erase confirm wants three row cycles, the other starts five full ones
			if ((mode == 8'hd0 && acnt != 8'h03) || ((mode == 8'h35 || mode == 8'h10
				|| mode == 8'h11) && acnt != 8'h05)) begin
				seq_err = 1'b1;
			end
			acnt = 8'h00;
			if (mode == 8'h35 || mode == 8'h10 || mode == 8'h11 || mode == 8'hd0) begin
				ready = 1'b0;
				err = fail && mode == 8'h10;
				#(mode == 8'h11 ? 200 : 600) ready = 1'b1;
			end
		end
	end
	// live status, fail bit 0 in every readout, bit 2 only in the check readout; no partial rewrite, so always valid
	assign stat = {write_prot_n, ready, 3'h0, mode == 8'h7b, 1'b0, err};
	// released bus shows inverted data so stale values never match
	assign io_dev = host_oe != 8'h00 ? io_host :
		(!chip_en_n && !read_strobe_n) ? stat : ~stat;
endmodule // ncs_flash_model
`default_nettype wire

// [tb/ncs_seq_tb.sv]
`timescale 1ns/10ps
`default_nettype none
`include "ncs_params.svh"
module ncs_seq_tb;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic [4:0] aw = 5'h00, ar = 5'h00;
	logic awv = 1'b0, wv = 1'b0, bready = 1'b0, arv = 1'b0, rready = 1'b0;
	logic [31:0] wd = 32'h0;
	logic awr, wr, bvalid, arr, rvalid, cle, ce_n, we_n, re_n, rdy, fail = 1'b0;
	logic ale, wp_n, seq_err;
	logic [1:0] bresp, rresp, r;
	logic [31:0] rdata, d;
	logic [7:0] io_o, io_oe, io_i;
	int bad_count = 0, checked = 0, cycles = 0;
	logic [2:0] ops [6] = '{3'h1, 3'h2, 3'h0, 3'h4, 3'h5, 3'h6};
	logic [7:0] exps [6] = '{8'hc0, 8'hc0, 8'hc4, 8'hc4, 8'hc0, 8'hc4};
	always #2.5 clk = ~clk;
	ncs_seq uut (.CORE_CLK(clk), .NRST(nrst), .S_AXI_AWADDR(aw), .S_AXI_AWVALID(awv),
		.S_AXI_AWREADY(awr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wv),
		.S_AXI_WREADY(wr), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
		.S_AXI_ARADDR(ar), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdata),
		.S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .NAND_CLE(cle),
		.NAND_ALE(ale), .NAND_CHIP_EN_N(ce_n), .NAND_WRITE_STROBE_N(we_n),
		.NAND_READ_STROBE_N(re_n), .NAND_WRITE_PROT_N(wp_n), .NAND_IO_I(io_i),
		.NAND_IO_O(io_o), .NAND_IO_OE(io_oe), .NAND_READY(rdy));
	ncs_flash_model dev (.chip_en_n(ce_n), .cle(cle), .ale(ale), .write_strobe_n(we_n),
		.read_strobe_n(re_n), .write_prot_n(wp_n), .io_host(io_o), .host_oe(io_oe),
		.fail(fail), .io_dev(io_i), .ready(rdy), .seq_err(seq_err));
	task automatic axi_wr(input logic [4:0] a, input logic [31:0] v);
		logic ad;
		logic wdn;
		ad = 1'b0;
		wdn = 1'b0;
		@(posedge clk);
		aw <= a; wd <= v; awv <= 1'b1; wv <= 1'b1; bready <= 1'b1;
		// each channel lets go of its valid only when its own ready is seen
		do begin
			@(posedge clk);
			if (awr === 1'b1 && !ad) begin
				ad = 1'b1;
				awv <= 1'b0;
			end
			if (wr === 1'b1 && !wdn) begin
				wdn = 1'b1;
				wv <= 1'b0;
			end
		end while (!(ad && wdn));
		while (bvalid !== 1'b1) @(posedge clk);
		r = bresp;
		bready <= 1'b0;
	endtask
	task automatic axi_rd(input logic [4:0] a);
		@(posedge clk);
		ar <= a; arv <= 1'b1; rready <= 1'b1;
		do @(posedge clk); while (arr !== 1'b1);
		arv <= 1'b0;
		while (rvalid !== 1'b1) @(posedge clk);
		d = rdata; r = rresp;
		rready <= 1'b0;
	endtask
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
		checked++;
		if (s !== e) begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", n, e, s);
		end
	endtask
	// poll for done, then compare the last device status byte
	task automatic finish_op(input logic [7:0] e);
		do axi_rd(`NCS_OFF_STATUS); while (d[`NCS_ST_DONE] !== 1'b1);
		chk("status byte", {24'h0, e}, {24'h0, d[7:0]});
	endtask
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	// hang guard, well above the longest sequence
	always @(posedge clk) begin
		cycles++;
		if (cycles == 60000) begin
			bad_count++;
			print_verdict;
		end
	end
	initial begin
		repeat (8) @(posedge clk);
		nrst <= 1'b1;
		for (int i = 0; i < 6; i++) begin
			axi_wr(`NCS_OFF_CTRL, {28'h0, ops[i], 1'b1});
			finish_op(exps[i]);
			$display("test op %0d ended", ops[i]);
		end
		// two-plane program, one byte per plane, device reports a failure
		fail <= 1'b1;
		axi_wr(`NCS_OFF_COUNT, 32'h1);
		axi_wr(`NCS_OFF_CTRL, 32'h7);
		for (int i = 0; i < 2; i++) begin
			do axi_rd(`NCS_OFF_STATUS); while (d[`NCS_ST_WFULL] !== 1'b0);
			axi_wr(`NCS_OFF_WDATA, 32'h5a);
		end
		finish_op(8'hc1);
		$display("test program pair ended");
		// parity mismatch and unknown op are both refused
		axi_wr(`NCS_OFF_DST, 32'h1);
		axi_wr(`NCS_OFF_CTRL, 32'h1);
		axi_rd(`NCS_OFF_STATUS);
		chk("refused parity", 32'h1, {31'h0, d[`NCS_ST_REFUSED]});
		// an accepted status op clears the flag, so the next refusal is seen afresh
		axi_wr(`NCS_OFF_CTRL, 32'hb);
		finish_op(8'hc1);
		chk("refused cleared", 32'h0, {31'h0, d[`NCS_ST_REFUSED]});
		axi_wr(`NCS_OFF_CTRL, 32'hf);
		axi_rd(`NCS_OFF_STATUS);
		chk("refused op", 32'h1, {31'h0, d[`NCS_ST_REFUSED]});
		axi_wr(`NCS_OFF_STATUS, 32'h0);
		chk("status write resp", 32'h2, {30'h0, r});
		axi_rd(5'h1c);
		chk("unmapped resp", 32'h2, {30'h0, r});
		chk("address cycles", 32'h0, {31'h0, seq_err});
		$display("test refusals ended");
		print_verdict;
	end
endmodule // ncs_seq_tb
`default_nettype wire
